// File: pdmp_pkg.sv
// Package for the palette DAC micro port register logic: offsets, fields, reset values.
package pdmp_pkg;

  // ***********************************************************
  // Register-select locations
  // ***********************************************************
  localparam logic [1:0] PDMP_RS_WRITE_ADDR = 2'h0;
  localparam logic [1:0] PDMP_RS_COLOUR     = 2'h1;
  localparam logic [1:0] PDMP_RS_MASK       = 2'h2;
  localparam logic [1:0] PDMP_RS_READ_ADDR  = 2'h3;

  // ***********************************************************
  // Extended register indexes
  // ***********************************************************
  localparam logic [15:0] PDMP_IDX_MAKER     = 16'h0000;
  localparam logic [15:0] PDMP_IDX_PART      = 16'h0001;
  localparam logic [15:0] PDMP_IDX_RESERVED  = 16'h0002;
  localparam logic [15:0] PDMP_IDX_PRI_MODE  = 16'h0003;
  localparam logic [15:0] PDMP_IDX_SEC_MODE  = 16'h0004;
  localparam logic [15:0] PDMP_IDX_PLL       = 16'h0005;
  localparam logic [15:0] PDMP_IDX_SOFT_RST  = 16'h0006;

  // ***********************************************************
  // Fields and reset values
  // ***********************************************************
  localparam int          PDMP_CMD_EXT_SPACE_BIT = 4;
  localparam logic [7:0]  PDMP_CMD_RESET     = 8'h00;
  localparam logic [7:0]  PDMP_MASK_RESET    = 8'hFF;
  localparam logic [7:0]  PDMP_PLL_RESET     = 8'h02;
  localparam logic [7:0]  PDMP_PLL_WMASK     = 8'h03;
  localparam logic [7:0]  PDMP_INDEX_RESET   = 8'h00;
  localparam logic [7:0]  PDMP_MODE_RESET    = 8'h00;
  localparam int          PDMP_SOFT_RST_BIT  = 0;

  // Access sequence states
  typedef enum logic [2:0] {
    PDMP_S1, PDMP_S2, PDMP_S3, PDMP_S4, PDMP_S5, PDMP_S_IDX_LO, PDMP_S_IDX_HI, PDMP_S_INDEXED
  } pdmp_state_t;

  // Decoded command register controls
  typedef struct packed {
    logic [2:0] colour_format;
    logic       ext_space_en;
    logic       ext_pixel_en;
    logic       pedestal_en;
    logic       ram_8bit;
    logic       sleep;
  } pdmp_cmd_t;

endpackage

// File: pdmp_regs.sv
// Micro port register logic of a palette DAC with extended indexed register space.
//
// Notes on behaviour
// - Each location-2 read before indexed access advances sequence state
// - States 1-4 read mask; fifth reads command
// - Next two location-2 accesses hit index bytes
// - Then indexed access, index increments afterwards
// - Access to other location resets to state 1
// - Sequence starts at state 1 after reset
// - Extended space disabled: state 5 read returns 1
// - Select bits: write addr, colour, mask, read addr
// - Index map: ids, reserved, modes, PLL, soft reset
// - Bit4 extended space, bit3 extended pixel modes
// - Bit2 adds blanking pedestal
// - Bit1 selects 8-bit palette transfers
// - Bit0 sleep, micro port stays usable
// - Index low and high bytes reset zero
// - Indexes 0 and 1 read-only identity codes
// - Pixel mode selects hold codes, not reset
// - PLL range bits 1:0, reset 10
// - Soft reset bit restores power-on defaults
// - Select bits captured at strobe falling edge
// - Write data stored at write strobe rising edge
module pdmp_regs
  import pdmp_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A   // Arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [1:0] register_select,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  output logic      [1:0] rs_addr_sel,
  output logic      [7:0] rs_addr_wdata,
  output logic            rs_addr_wr,
  output logic            rs_addr_rd,
  input  wire logic [7:0] rs_addr_rdata,
  output pdmp_cmd_t       cmd_ctrl,
  output logic      [7:0] pixel_mask,
  output logic      [7:0] primary_mode,
  output logic      [7:0] secondary_mode,
  output logic      [1:0] pll_range
);

  // ***********************************************************
  // Strobe edge detection
  // ***********************************************************
  logic        rd_q_reg;
  logic        wr_q_reg;
  logic [1:0]  sel_reg;
  logic        sel_is_wr_reg;
  pdmp_state_t state_reg;
  pdmp_state_t state_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  idx_lo_reg;
  logic [7:0]  idx_hi_reg;
  logic [7:0]  pri_mode_reg;
  logic [7:0]  sec_mode_reg;
  logic [7:0]  pll_reg;
  logic [7:0]  rdata_reg;

  wire rd_fall = rd_q_reg & ~read_strobe_n;
  wire rd_rise = ~rd_q_reg & read_strobe_n;
  wire wr_fall = wr_q_reg & ~write_strobe_n;
  wire wr_rise = ~wr_q_reg & write_strobe_n;

  // Limitation: there is no synchroniser in front of the edge detectors, so
  // the strobes and select bits must already be synchronous to clk_sys.
  // A strobe low for a single clock already counts as one access, though the bus is driven only from the second;
  // real controllers hold their strobes far longer than that at this rate.
  // Strobes are sampled as synchronous inputs; edges are one-cycle pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_q_reg <= 1'b1;
      wr_q_reg <= 1'b1;
    end else begin
      rd_q_reg <= read_strobe_n;
      wr_q_reg <= write_strobe_n;
    end
  end

  // Select bits are held from the falling edge so late bus changes do no harm
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg       <= PDMP_RS_WRITE_ADDR;
      sel_is_wr_reg <= 1'b0;
    end else if (rd_fall | wr_fall) begin
      sel_reg       <= register_select;
      sel_is_wr_reg <= wr_fall;
    end
  end

  // ***********************************************************
  // Access decode
  // ***********************************************************
  // A read completes at the strobe falling edge (data must be ready early);
  // a write completes at the rising edge with the captured select bits.
  wire       sel_now_mask = (register_select == PDMP_RS_MASK);
  wire       rd_mask      = rd_fall & sel_now_mask;
  wire       rd_other     = rd_fall & ~sel_now_mask;
  wire       wr_done      = wr_rise & sel_is_wr_reg;
  wire       wr_mask      = wr_done & (sel_reg == PDMP_RS_MASK);
  wire       wr_other     = wr_done & (sel_reg != PDMP_RS_MASK);
  wire       mask_acc     = rd_mask | wr_mask;
  wire [15:0] index       = {idx_hi_reg, idx_lo_reg};
  wire       ext_en       = cmd_reg[PDMP_CMD_EXT_SPACE_BIT];
  wire       indexed_wr   = wr_mask & (state_reg == PDMP_S_INDEXED);
  // Soft reset acts at the write strobe rise that carries the set bit
  wire       soft_reset   = indexed_wr & (index == PDMP_IDX_SOFT_RST)
                            & host_data_in[PDMP_SOFT_RST_BIT];

  // ***********************************************************
  // Per-register write enables
  // ***********************************************************
  // Decoded once here so the register processes below stay short
  wire       mask_wr      = wr_mask & (state_reg inside {PDMP_S1, PDMP_S2, PDMP_S3, PDMP_S4});
  wire       cmd_wr       = wr_mask & (state_reg == PDMP_S5);
  wire       idx_lo_wr    = wr_mask & (state_reg == PDMP_S_IDX_LO);
  wire       idx_hi_wr    = wr_mask & (state_reg == PDMP_S_IDX_HI);
  wire       idx_step     = mask_acc & (state_reg == PDMP_S_INDEXED);
  wire       pri_wr       = indexed_wr & (index == PDMP_IDX_PRI_MODE);
  wire       sec_wr       = indexed_wr & (index == PDMP_IDX_SEC_MODE);
  wire       pll_wr       = indexed_wr & (index == PDMP_IDX_PLL);

  // Other locations go to the outer palette logic
  assign rs_addr_sel   = rd_fall ? register_select : sel_reg;
  assign rs_addr_wdata = host_data_in;
  assign rs_addr_wr    = wr_other;
  assign rs_addr_rd    = rd_other;

  // ***********************************************************
  // Access sequence state counter
  // ***********************************************************
  // Next state: other locations restart, writes in states 1-5 restart
  always_comb begin
    state_next = state_reg;
    if (rd_other | wr_other) begin
      state_next = PDMP_S1;
    end else if (mask_acc) begin
      unique case (state_reg)
        PDMP_S1:        state_next = wr_mask ? PDMP_S1 : PDMP_S2;
        PDMP_S2:        state_next = wr_mask ? PDMP_S1 : PDMP_S3;
        PDMP_S3:        state_next = wr_mask ? PDMP_S1 : PDMP_S4;
        PDMP_S4:        state_next = wr_mask ? PDMP_S1 : PDMP_S5;
        PDMP_S5:        state_next = (rd_mask & ext_en) ? PDMP_S_IDX_LO : PDMP_S1;
        PDMP_S_IDX_LO:  state_next = PDMP_S_IDX_HI;
        PDMP_S_IDX_HI:  state_next = PDMP_S_INDEXED;
        PDMP_S_INDEXED: state_next = PDMP_S_INDEXED;
      endcase
    end
  end

  // Soft reset also restarts the sequence so the host finds a known state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PDMP_S1;
    end else if (soft_reset) begin
      state_reg <= PDMP_S1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***********************************************************
  // Direct registers: mask, command, index bytes
  // ***********************************************************
  // Pixel mask: writes only land in states 1-4
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= PDMP_MASK_RESET;
    end else if (soft_reset) begin
      mask_reg <= PDMP_MASK_RESET;
    end else if (mask_wr) begin
      mask_reg <= host_data_in;
    end
  end

  // Command register written in state 5; soft reset restores defaults
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= PDMP_CMD_RESET;
    end else if (soft_reset) begin
      cmd_reg <= PDMP_CMD_RESET;
    end else if (cmd_wr) begin
      cmd_reg <= host_data_in;
    end
  end

  // Index bytes: loaded in states 6/7, auto-increment after indexed accesses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_lo_reg <= PDMP_INDEX_RESET;
      idx_hi_reg <= PDMP_INDEX_RESET;
    end else if (soft_reset) begin
      idx_lo_reg <= PDMP_INDEX_RESET;
      idx_hi_reg <= PDMP_INDEX_RESET;
    end else if (idx_lo_wr) begin
      idx_lo_reg <= host_data_in;
    end else if (idx_hi_wr) begin
      idx_hi_reg <= host_data_in;
    end else if (idx_step) begin
      {idx_hi_reg, idx_lo_reg} <= index + 16'h0001;
    end
  end

  // ***********************************************************
  // Extended registers
  // ***********************************************************
  // Mode selects are not reset by power-on, so soft reset leaves them too;
  // a defined value is still given at rst_n to keep simulation clean
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pri_mode_reg <= PDMP_MODE_RESET;
      sec_mode_reg <= PDMP_MODE_RESET;
    end else begin
      if (pri_wr) begin
        pri_mode_reg <= host_data_in;
      end
      if (sec_wr) begin
        sec_mode_reg <= host_data_in;
      end
    end
  end

  // PLL range: reserved bits 7:2 are never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_reg <= PDMP_PLL_RESET;
    end else if (soft_reset) begin
      pll_reg <= PDMP_PLL_RESET;
    end else if (pll_wr) begin
      pll_reg <= host_data_in & PDMP_PLL_WMASK;
    end
  end

  // ***********************************************************
  // Read data path
  // ***********************************************************
  logic [7:0] ext_rdata;
  logic [7:0] mask_rdata;

  // Indexed read map; reserved and unmapped indexes read zero
  always_comb begin
    unique case (index)
      PDMP_IDX_MAKER:    ext_rdata = MAKER_CODE;
      PDMP_IDX_PART:     ext_rdata = PART_CODE;
      PDMP_IDX_PRI_MODE: ext_rdata = pri_mode_reg;
      PDMP_IDX_SEC_MODE: ext_rdata = sec_mode_reg;
      PDMP_IDX_PLL:      ext_rdata = pll_reg;
      default:           ext_rdata = 8'h00;
    endcase
  end

  // Register mapped at location 2 for each sequence state
  always_comb begin
    unique case (state_reg)
      PDMP_S5:        mask_rdata = cmd_reg;
      PDMP_S_IDX_LO:  mask_rdata = idx_lo_reg;
      PDMP_S_IDX_HI:  mask_rdata = idx_hi_reg;
      PDMP_S_INDEXED: mask_rdata = ext_rdata;
      default:        mask_rdata = mask_reg;
    endcase
  end

  // Reads are served from the state before the step, so the sequence step
  // and the returned data always agree, however late the strobe rises.
  // Data captured at the falling edge and held until the strobe rises
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_fall) begin
      rdata_reg <= sel_now_mask ? mask_rdata : rs_addr_rdata;
    end
  end

  // Bus enabled one clock after the strobe falls, once the data flop is loaded
  assign host_data_out = rdata_reg;
  assign host_data_oe  = ~rd_q_reg & ~read_strobe_n;

  // ***********************************************************
  // Control outputs
  // ***********************************************************
  // Straight from the registers; reserved PLL bits never leave the block
  assign cmd_ctrl       = pdmp_cmd_t'(cmd_reg);
  assign pixel_mask     = mask_reg;
  assign primary_mode   = pri_mode_reg;
  assign secondary_mode = sec_mode_reg;
  assign pll_range      = pll_reg[1:0];

endmodule

// File: pdmp_regs_chk.sv
// Assertion checker for the micro port register logic.
module pdmp_regs_chk
  import pdmp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] host_data_in,
  input wire logic       host_data_oe,
  input wire logic [1:0] rs_addr_sel,
  input wire logic [7:0] rs_addr_wdata,
  input wire logic       rs_addr_wr,
  input wire logic       rs_addr_rd,
  input wire pdmp_cmd_t  cmd_ctrl,
  input wire logic [7:0] pixel_mask,
  input wire logic [1:0] pll_range
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default for all properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  reset_vals_a: assert property ($rose(rst_n) |->
    cmd_ctrl == PDMP_CMD_RESET && pll_range == 2'h2 && pixel_mask == PDMP_MASK_RESET)
    else $error("register values wrong after reset");
  read_drive_a: assert property (!read_strobe_n [*3] |-> host_data_oe)
    else $error("data bus not driven during read");
  idle_float_a: assert property (read_strobe_n |-> !host_data_oe)
    else $error("data bus driven outside a read");
  write_float_a: assert property (!write_strobe_n |-> !host_data_oe)
    else $error("data bus driven during write");
  outer_rd_a: assert property (rs_addr_rd |-> !read_strobe_n && rs_addr_sel != 2'h2)
    else $error("outer read outside a read or at location two");
  outer_wr_a: assert property (rs_addr_wr |-> write_strobe_n && rs_addr_sel != 2'h2)
    else $error("outer write before strobe rise or at location two");
  pulse_once_a: assert property (rs_addr_rd || rs_addr_wr |=> !rs_addr_rd && !rs_addr_wr)
    else $error("outer access pulse longer than one clock");
  wdata_pass_a: assert property (rs_addr_wdata == host_data_in)
    else $error("outer write data differs from bus");
  write_only_a: assert property (!$stable({cmd_ctrl, pixel_mask, pll_range}) |->
    !$past(write_strobe_n, 2) || !$past(write_strobe_n))
    else $error("register changed without a write");

  // Main traffic kinds
  cover property (rs_addr_rd);
  cover property (rs_addr_wr);
  cover property ($rose(cmd_ctrl.ext_space_en));
endmodule

bind pdmp_regs pdmp_regs_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .host_data_in(host_data_in), .host_data_oe(host_data_oe), .rs_addr_sel(rs_addr_sel),
  .rs_addr_wdata(rs_addr_wdata), .rs_addr_wr(rs_addr_wr), .rs_addr_rd(rs_addr_rd),
  .cmd_ctrl(cmd_ctrl), .pixel_mask(pixel_mask), .pll_range(pll_range));

// File: pdmp_host.sv
// Graphics controller model driving the micro port and serving outer palette reads.
module pdmp_host #(
  parameter logic [7:0] PAL = 8'h96
) (
  input  wire logic       clk_sys,
  input  wire logic [7:0] host_data_out,
  output logic      [1:0] register_select,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic      [7:0] host_data_in,
  output logic      [7:0] rs_addr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobes idle high
  initial begin
    register_select = 2'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_data_in = 8'h00;
    rs_addr_rdata = PAL;
  end

  // Read: strobe low four clocks; select moves at release to catch late sampling
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    register_select = a;
    read_strobe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    d = host_data_out;
    read_strobe_n = 1'b1;
    register_select = ~a;
    repeat (3) @(negedge clk_sys);
  endtask

  // Write: data held one clock past the rise, then inverted, never left stale
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    register_select = a;
    host_data_in = v;
    write_strobe_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    write_strobe_n = 1'b1;
    register_select = ~a;
    @(negedge clk_sys);
    host_data_in = ~v;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

// File: tb_top.sv
// Self-checking testbench of the micro port register logic.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pdmp_pkg::*;

  localparam logic [7:0] MAKER = 8'hC3;  // Arbitrary value
  localparam logic [7:0] PART  = 8'h3C;  // Arbitrary value
  localparam logic [7:0] PAL   = 8'h96;

  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic [1:0] register_select, pll_range;
  logic       read_strobe_n, write_strobe_n, host_data_oe;
  logic [7:0] host_data_in, host_data_out, rs_addr_rdata;
  logic [7:0] pixel_mask, primary_mode, secondary_mode, d;
  pdmp_cmd_t  cmd_ctrl;
  int         fails = 0;
  int         num_checks = 0;

  always #2 clk_sys = ~clk_sys;

  pdmp_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .register_select(register_select), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .rs_addr_sel(),
    .rs_addr_wdata(), .rs_addr_wr(), .rs_addr_rd(), .rs_addr_rdata(rs_addr_rdata),
    .cmd_ctrl(cmd_ctrl), .pixel_mask(pixel_mask), .primary_mode(primary_mode),
    .secondary_mode(secondary_mode), .pll_range(pll_range));

  pdmp_host #(.PAL(PAL)) host (.clk_sys(clk_sys), .host_data_out(host_data_out),
    .register_select(register_select), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .host_data_in(host_data_in),
    .rs_addr_rdata(rs_addr_rdata));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    host.rd(a, v);
    check(nm, v, exp);
  endtask

  // Restart the sequence through another location, then n mask-location reads
  task automatic go(input int n);
    host.rd(PDMP_RS_READ_ADDR, d);
    repeat (n) host.rd(PDMP_RS_MASK, d);
  endtask

  task automatic goidx(input logic [15:0] i);
    go(5);
    host.wr(PDMP_RS_MASK, i[7:0]);
    host.wr(PDMP_RS_MASK, i[15:8]);
  endtask

  task automatic t_power();
    check("command", cmd_ctrl, PDMP_CMD_RESET);
    repeat (4) rchk(PDMP_RS_MASK, PDMP_MASK_RESET, "mask");
    rchk(PDMP_RS_MASK, PDMP_CMD_RESET, "command read");
    rchk(PDMP_RS_MASK, PDMP_MASK_RESET, "mask after state 5");
  endtask

  // Other locations, read or written mid-sequence, restart it
  task automatic t_outer();
    logic [1:0] locs[3] = '{PDMP_RS_WRITE_ADDR, PDMP_RS_COLOUR, PDMP_RS_READ_ADDR};
    foreach (locs[k]) begin
      go(3);
      if (k == 1) host.wr(locs[k], 8'h00);
      else rchk(locs[k], PAL, "outer read");
      repeat (4) host.rd(PDMP_RS_MASK, d);
      rchk(PDMP_RS_MASK, PDMP_CMD_RESET, "command after restart");
    end
  endtask

  task automatic t_maskwr();
    go(2);
    host.wr(PDMP_RS_MASK, 8'h3C);
    check("mask", pixel_mask, 8'h3C);
    repeat (4) rchk(PDMP_RS_MASK, 8'h3C, "mask readback");
    rchk(PDMP_RS_MASK, PDMP_CMD_RESET, "command after mask write");
  endtask

  // Colour format codes 0, 5, 6 and 7, all control bits set; sleep leaves the port usable
  task automatic t_cmd();
    logic [2:0] fmt[4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    foreach (fmt[k]) begin
      go(4);
      host.wr(PDMP_RS_MASK, {fmt[k], 5'h1F});
      check("command", cmd_ctrl, {fmt[k], 5'h1F});
      go(4);
      rchk(PDMP_RS_MASK, {fmt[k], 5'h1F}, "command read");
    end
  endtask

  task automatic t_index();
    go(5);
    host.rd(PDMP_RS_MASK, d);
    host.rd(PDMP_RS_MASK, d);
    rchk(PDMP_RS_MASK, MAKER, "maker at reset index");
    goidx(PDMP_IDX_PRI_MODE);
    host.wr(PDMP_RS_MASK, 8'h04);
    host.wr(PDMP_RS_MASK, 8'h02);
    host.wr(PDMP_RS_MASK, 8'h01);
    check("primary", primary_mode, 8'h04);
    check("secondary", secondary_mode, 8'h02);
    check("pll", {6'h00, pll_range}, 8'h01);
    goidx(PDMP_IDX_MAKER);
    host.wr(PDMP_RS_MASK, 8'h77);
    rchk(PDMP_RS_MASK, PART, "part after write");
    goidx(PDMP_IDX_MAKER);
    rchk(PDMP_RS_MASK, MAKER, "maker");
    repeat (2) host.rd(PDMP_RS_MASK, d);
    rchk(PDMP_RS_MASK, 8'h04, "primary read");
    rchk(PDMP_RS_MASK, 8'h02, "secondary read");
    rchk(PDMP_RS_MASK, 8'h01, "pll read");
  endtask

  task automatic t_soft();
    goidx(PDMP_IDX_SOFT_RST);
    host.wr(PDMP_RS_MASK, 8'h01);
    check("command", cmd_ctrl, PDMP_CMD_RESET);
    check("mask", pixel_mask, PDMP_MASK_RESET);
    check("pll", {6'h00, pll_range}, PDMP_PLL_RESET);
    check("primary kept", primary_mode, 8'h04);
    go(5);
    rchk(PDMP_RS_MASK, PDMP_MASK_RESET, "mask after soft reset");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after a 16-clock reset
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    t_power();
    t_outer();
    t_maskwr();
    t_cmd();
    t_index();
    t_soft();
    complete_run();
  end

  // Watchdog: the run needs about 1200 clocks
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
